/* File: src/hbc_bridge_ctrl.sv */
// Purpose: chopping current regulation, dead time, overcurrent policy and fault pin.
// Assumes: analog comparators and strap decoders outside; one 10 MHz clock.
// Notes: sleep acts as a full internal reset; variant and mode straps latch when the core turns ready, slew and regulation-disable straps are read live.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module hbc_bridge_ctrl #(
	parameter int RETRY_CYC = hbc_pkg::RETRY_CYC_DEF
) (
	input  wire logic                      mclk_i,
	input  wire logic                      reset_i,
	input  wire logic                      sleep_n_i,
	input  wire logic                      in1_i,
	input  wire logic                      in2_i,
	input  wire logic                      disable_i,
	input  wire logic [1:0]                regulation_trip_i,
	input  wire logic [1:0]                ocp_i,
	input  wire logic                      variant_serial_i,
	input  wire logic [1:0]                mode_strap_i,
	input  wire logic                      regulation_disable_strap_n_i,
	input  wire logic [2:0]                slew_strap_i,
	input  wire logic [hbc_pkg::REG_AW-1:0] reg_addr_i,
	input  wire logic [hbc_pkg::REG_DW-1:0] reg_wdata_i,
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	output logic      [hbc_pkg::REG_DW-1:0] reg_rdata_o,
	output logic      [1:0]                hs_on_o,
	output logic      [1:0]                ls_on_o,
	output logic      [1:0]                trip_level_select_o,
	output logic      [2:0]                slew_select_o,
	output logic                           fault_out_n_o,
	output logic                           fault_out_n_oe_o,
	output logic                           awake_o
);
	import hbc_pkg::*;

	typedef struct packed {
		hbc_reg_e        st;
		logic [9:0]      cnt;
		logic [3:0]      dir;
		logic [3:0]      cmd;
		logic [15:0]     retry;
		logic [1:0]      ocp_flag;
		logic [1:0][4:0] dead;
		logic [1:0][1:0] drv;
		logic [6:0]      rdy_cnt;
		logic            rdy;
		logic            serial;
		logic [1:0]      mode_pin;
		logic [1:0]      outdis;
		logic [5:0]      ctrl4;
		logic [6:0]      cfg;
		logic [2:0]      sr;
		logic [1:0]      tl;
		logic [7:0]      rdata;
	} hbc_state_s;

	localparam hbc_state_s ST_RST = '{st: RG_BLANK, ctrl4: CTRL4_RST, cfg: CFG_RST, default: '0};

	hbc_state_s      q;
	hbc_state_s      nxt;
	logic [2:0]      in_f;
	logic [11:0]     pin_f;
	logic            sleep_s;
	logic [1:0]      trip_s;
	logic [1:0]      ocp_s;
	logic [1:0]      dmask;
	logic [1:0]      decay_period_select;
	logic [1:0]      pol;
	logic [1:0]      mode;
	logic [2:0]      sr_eff;
	logic [1:0]      trip_eff;
	logic [1:0]      ev;
	logic [1:0]      shut;
	logic            clr;
	logic            opp;
	logic            fault_any;
	logic [1:0][1:0] cmd;
	logic [1:0][1:0] tgt;

	// control inputs get the longer deglitch window
	hbc_pin_filter #(
		.W   (3),
		.DG  (DGL_CYC),
		.RST (3'h4)
	) u_in_flt (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.pin_i   ({disable_i, in2_i, in1_i}),
		.filt_o  (in_f)
	);

	// comparator flags, sleep and straps are only synchronised
	hbc_pin_filter #(
		.W   (12),
		.DG  (1),
		.RST (12'h000)
	) u_pin_sync (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.pin_i   ({slew_strap_i, mode_strap_i, regulation_disable_strap_n_i,
		           variant_serial_i, ocp_i, regulation_trip_i, sleep_n_i}),
		.filt_o  (pin_f)
	);

	assign sleep_s = pin_f[0];
	assign trip_s  = pin_f[2:1];
	assign ocp_s   = pin_f[4:3];

	// effective settings: registers in the serial variant, fixed or strapped otherwise
	assign decay_period_select   = q.serial ? q.ctrl4[C4_DECAY_PERIOD_SELECT+:2] : DECAY_PERIOD_SELECT_PIN;
	assign dmask  = q.serial ? q.ctrl4[C4_DMASK+:2] : {2{pin_f[6]}};
	assign pol    = q.serial ? q.cfg[CF_POL+:2] : 2'h0;
	assign mode   = q.serial ? q.cfg[CF_MODE+:2] : q.mode_pin;
	assign sr_eff = q.serial ? q.cfg[CF_SLEW+:3] : strap_slew(pin_f[11:9]);

	// only outputs with regulation enabled can trip
	assign trip_eff = trip_s & ~dmask;
	assign clr      = reg_wr_i && q.rdy && reg_addr_i == OFS_CTRL3 && reg_wdata_i[C3_CLR];

	// non-independent modes shut the whole bridge on either half
	assign ev = (pol == POL_NONE) ? 2'h0 : (mode == MD_IND) ? ocp_s : {2{|ocp_s}};
	assign fault_any = |q.ocp_flag;

	// latched and retry policies turn the bridge off; report-only keeps driving
	assign shut = {2{!q.rdy || in_f[2]}} | (q.ocp_flag & {2{!pol[1]}});

	// input decode per control mode, index 0 is output one
	always_comb begin
		cmd = {HB_Z, HB_Z};
		unique case (mode)
			MD_PHEN: cmd = !in_f[0] ? {HB_H, HB_H} : in_f[1] ? {HB_L, HB_H} : {HB_H, HB_L};
			MD_PWM: begin
				cmd[0] = in_f[0] ? HB_H : in_f[1] ? HB_L : HB_Z;
				cmd[1] = in_f[1] ? HB_H : in_f[0] ? HB_L : HB_Z;
			end
			MD_IND: begin
				cmd[0] = q.outdis[0] ? HB_Z : in_f[0] ? HB_H : HB_L;
				cmd[1] = q.outdis[1] ? HB_Z : in_f[1] ? HB_H : HB_L;
			end
			default: cmd = {HB_Z, HB_Z};
		endcase
	end

	// a reversed drive pair during decay speeds it up
	assign opp = (q.dir == {HB_L, HB_H} || q.dir == {HB_H, HB_L}) && cmd == {q.dir[1:0], q.dir[3:2]};

	// during off time both high sides conduct, unless the reversed drive pair is commanded
	always_comb begin
		tgt = cmd;
		if (q.st == RG_OFF && !opp) begin
			tgt = {HB_H, HB_H};
		end
		for (int i = 0; i < 2; i++) begin
			if (shut[i]) begin
				tgt[i] = HB_Z;
			end
		end
	end

	// next-state of the whole controller
	always_comb begin
		nxt = q;
		nxt.rdata = '0;
		nxt.cmd = cmd;
		nxt.sr = sr_eff;
		nxt.tl = q.serial ? q.ctrl4[C4_TRIP+:2] : TRIP_PIN;

		// core comes up a fixed time after wake; variant and mode straps latch then
		if (!q.rdy) begin
			if (q.rdy_cnt == 7'(READY_CYC - 1)) begin
				nxt.rdy = 1'b1;
				nxt.serial = pin_f[5];
				nxt.mode_pin = pin_f[8:7];
			end else begin
				nxt.rdy_cnt = q.rdy_cnt + 7'h01;
			end
		end

		// regulation: blank, drive, off
		unique case (q.st)
			RG_BLANK: begin
				if (q.cnt == 10'h000) begin
					nxt.st = RG_DRIVE; // trip ignored until here
				end else begin
					nxt.cnt = q.cnt - 10'h001;
				end
			end
			RG_DRIVE: begin
				if (|trip_eff) begin
					nxt.st = RG_OFF;
					nxt.cnt = off_cycles(decay_period_select);
					nxt.dir = cmd;
				end else if (cmd != q.cmd) begin
					nxt.st = RG_BLANK; // new drive period restarts blanking
					nxt.cnt = 10'(BLANK_CYC);
				end
			end
			RG_OFF: begin
				if (q.cnt <= 10'h001) begin
					if (|trip_eff) begin
						nxt.cnt = off_cycles(decay_period_select);
					end else begin
						nxt.st = RG_BLANK;
						nxt.cnt = 10'(BLANK_CYC);
					end
				end else begin
					nxt.cnt = q.cnt - 10'h001;
				end
			end
		endcase

		// overcurrent retry timer; the set side always wins over a clear
		if (|ev && pol == POL_RTRY) begin
			nxt.retry = 16'(RETRY_CYC);
		end else if (q.retry != 16'h0000) begin
			nxt.retry = q.retry - 16'h0001;
		end
		nxt.ocp_flag = ev | (q.ocp_flag & ~{2{clr || (pol == POL_RTRY && q.retry == 16'h0000)}});

		// break before make on each half bridge
		for (int i = 0; i < 2; i++) begin
			if (q.dead[i] != 5'h00) begin
				nxt.dead[i] = q.dead[i] - 5'h01;
			end
			if (tgt[i] != q.drv[i]) begin
				if (q.drv[i] != HB_Z) begin
					nxt.drv[i] = HB_Z;
					nxt.dead[i] = dead_cycles(sr_eff);
				end else if (q.dead[i] == 5'h00) begin
					nxt.drv[i] = tgt[i];
				end
			end
		end

		// register port writes
		if (reg_wr_i && q.rdy) begin
			unique case (reg_addr_i)
				OFS_CTRL3: nxt.outdis = reg_wdata_i[C3_DIS+:2];
				OFS_CTRL4: nxt.ctrl4 = reg_wdata_i[5:0];
				OFS_CFG: nxt.cfg = reg_wdata_i[6:0];
				default: ;
			endcase
		end

		// read data stands for exactly one cycle; unmapped reads give zero
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_CTRL3: nxt.rdata = {5'h00, q.outdis, 1'b0};
				OFS_CTRL4: nxt.rdata = {2'h0, q.ctrl4};
				OFS_CFG: nxt.rdata = {1'b0, q.cfg};
				OFS_STATUS: nxt.rdata = {2'h0, q.rdy, q.serial, q.st == RG_OFF, q.ocp_flag, fault_any};
				default: nxt.rdata = '0;
			endcase
		end

		// sleep wipes everything, which also clears faults
		if (!sleep_s) begin
			nxt = ST_RST;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			q <= ST_RST;
		end else begin
			q <= nxt;
		end
	end

	// outputs straight from state bits
	assign reg_rdata_o         = q.rdata;
	assign hs_on_o             = {q.drv[1][0], q.drv[0][0]};
	assign ls_on_o             = {q.drv[1][1], q.drv[0][1]};
	assign trip_level_select_o = q.tl;
	assign slew_select_o       = q.sr;
	assign awake_o             = sleep_s;
	assign fault_out_n_o       = 1'b0;
	assign fault_out_n_oe_o    = fault_any || !q.rdy;

	// helper: cycles spent in one off period
	logic [9:0] off_age;
	always_ff @(posedge mclk_i) begin
		if (reset_i || q.st != RG_OFF || nxt.cnt == off_cycles(decay_period_select) && q.cnt <= 10'h001) begin
			off_age <= '0;
		end else begin
			off_age <= off_age + 10'h001;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	a_off_high_sides: assert property (q.st == RG_OFF && !opp && shut == 2'h0 |-> tgt == {HB_H, HB_H})
		else $error("off period does not turn both high sides on");
	a_off_max_len: assert property (q.st == RG_OFF |-> off_age < 10'd800)
		else $error("off period longer than the longest setting");
	a_decay_period_select_reset: assert property ($past(reset_i) |-> q.ctrl4[C4_DECAY_PERIOD_SELECT+:2] == 2'h1)
		else $error("decay selection not 01 after reset");
	a_pin_decay_period_select: assert property (q.rdy && !q.serial |-> decay_period_select == DECAY_PERIOD_SELECT_PIN)
		else $error("pin variant off time not fixed");
	a_off_resume: assert property (sleep_s && q.st == RG_OFF && q.cnt == 10'h001 && trip_eff == 2'h0
		|=> q.st == RG_BLANK)
		else $error("off period end did not resume drive");
	a_blank_ignore: assert property (q.st == RG_BLANK |=> q.st != RG_OFF)
		else $error("trip acted during blanking");
	a_pin_trip: assert property (sleep_s && q.rdy && !q.serial |=> trip_level_select_o == TRIP_PIN)
		else $error("pin variant trip level wrong");
	a_dead_gap: assert property ($rose(hs_on_o[0]) |-> !$past(ls_on_o[0]) && !ls_on_o[0])
		else $error("high side turned on without a dead gap");
	a_latch_off: assert property (q.ocp_flag[0] && pol == 2'h0 |=> !hs_on_o[0] && !ls_on_o[0])
		else $error("latched overcurrent left the output driven");
	a_fault_pin: assert property (fault_any |-> fault_out_n_oe_o && !fault_out_n_o)
		else $error("fault present but pin released");
	a_sleep_quiet: assert property (!sleep_s |=> reg_rdata_o == '0)
		else $error("read data returned while asleep");

	c_trip_entered: cover property (q.st == RG_DRIVE ##1 q.st == RG_OFF);
	c_off_rearmed: cover property (q.st == RG_OFF && q.cnt == 10'h001 && |trip_eff);
	c_reverse_decay: cover property (q.st == RG_OFF && opp);
	c_retry_done: cover property (pol == POL_RTRY && $fell(q.ocp_flag[0]));
endmodule : hbc_bridge_ctrl

/* File: src/hbc_pkg.sv */
// Purpose: shared constants, encodings and helpers for the H-bridge chopper controller.
// Assumes: 10 MHz core clock, 100 ns period.
// Notes: register offsets are byte addresses on the plain register port.
package hbc_pkg;
	localparam int CLK_NS = 100;
	localparam int REG_AW = 8;
	localparam int REG_DW = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL3  = 8'h00;
	localparam logic [7:0] OFS_CTRL4  = 8'h04;
	localparam logic [7:0] OFS_CFG    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// field positions
	localparam int C3_CLR   = 0;
	localparam int C3_DIS   = 1;
	localparam int C4_TRIP  = 0;
	localparam int C4_DMASK = 2;
	localparam int C4_DECAY_PERIOD_SELECT  = 4;
	localparam int CF_SLEW  = 0;
	localparam int CF_POL   = 3;
	localparam int CF_MODE  = 5;

	// reset values
	localparam logic [5:0] CTRL4_RST = 6'h12; // trip 10, mask 00 so both halves regulate, decay 01
	localparam logic [6:0] CFG_RST   = 7'h20;

	// fixed pin-variant settings
	localparam logic [1:0] DECAY_PERIOD_SELECT_PIN = 2'h1;
	localparam logic [1:0] TRIP_PIN = 2'h2;

	// modes, policies, half-bridge levels
	localparam logic [1:0] MD_PHEN  = 2'h0;
	localparam logic [1:0] MD_PWM   = 2'h1;
	localparam logic [1:0] MD_IND   = 2'h2;
	localparam logic [1:0] POL_NONE = 2'h3;
	localparam logic [1:0] POL_RTRY = 2'h1;
	localparam logic [1:0] HB_Z     = 2'h0;
	localparam logic [1:0] HB_H     = 2'h1;
	localparam logic [1:0] HB_L     = 2'h2;

	// timing
	localparam int T_DECAY_PERIOD_SELECT_STEP_US = 20;
	localparam int DECAY_PERIOD_SELECT_STEP_CYC  = T_DECAY_PERIOD_SELECT_STEP_US * 1000 / CLK_NS;
	localparam int T_BLANK_NS     = 2000;
	localparam int BLANK_CYC      = (T_BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_DGL_NS       = 500;
	localparam int DGL_CYC        = (T_DGL_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_READY_NS     = 10000;
	localparam int READY_CYC      = (T_READY_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_DEAD_NS      = 200;
	localparam int DEAD_CYC       = (T_DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RETRY_US     = 4000;
	localparam int RETRY_CYC_DEF  = T_RETRY_US * 1000 / CLK_NS;

	typedef enum logic [2:0] {
		RG_BLANK = 3'b001,
		RG_DRIVE = 3'b010,
		RG_OFF   = 3'b100
	} hbc_reg_e;

	// off period in cycles for a decay selection
	function automatic logic [9:0] off_cycles(input logic [1:0] sel);
		return 10'((int'(sel) + 1) * DECAY_PERIOD_SELECT_STEP_CYC);
	endfunction : off_cycles

	// slower edges need a longer gap
	function automatic logic [4:0] dead_cycles(input logic [2:0] sr);
		return 5'((int'(sr) + 1) * DEAD_CYC);
	endfunction : dead_cycles

	// strap level index 0..5, ground to supply; unknown reads as open
	function automatic logic [2:0] strap_slew(input logic [2:0] lvl);
		case (lvl)
			3'h0: return 3'h0;
			3'h1: return 3'h1;
			3'h2: return 3'h2;
			3'h4: return 3'h5;
			3'h5: return 3'h7;
			default: return 3'h3;
		endcase
	endfunction : strap_slew
endpackage : hbc_pkg

/* File: src/hbc_pin_filter.sv */
// Purpose: three-stage synchroniser with a per-bit stability filter.
// Assumes: inputs are asynchronous to mclk_i.
// Notes: a change counts once stages two and three agree for DG cycles.
`timescale 1ns/1ps
module hbc_pin_filter #(
	parameter int           W   = 1,
	parameter int           DG  = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         mclk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] filt_o
);
	localparam int CW = $clog2(DG + 1);

	typedef struct packed {
		logic [W-1:0]         s1;
		logic [W-1:0]         s2;
		logic [W-1:0]         s3;
		logic [W-1:0]         out;
		logic [W-1:0][CW-1:0] cnt;
	} hbc_flt_s;

	localparam hbc_flt_s FLT_RST = '{s1: RST, s2: RST, s3: RST, out: RST, cnt: '0};

	hbc_flt_s q;
	hbc_flt_s nxt;

	// stage one feeds stage two only, to keep metastability contained
	always_comb begin
		nxt = q;
		nxt.s1 = pin_i;
		nxt.s2 = q.s1;
		nxt.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i] && q.s3[i] != q.out[i]) begin
				if (q.cnt[i] == CW'(DG - 1)) begin
					nxt.out[i] = q.s3[i];
					nxt.cnt[i] = '0;
				end else begin
					nxt.cnt[i] = q.cnt[i] + 1'b1;
				end
			end else begin
				nxt.cnt[i] = '0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			q <= FLT_RST;
		end else begin
			q <= nxt;
		end
	end

	assign filt_o = q.out;
endmodule : hbc_pin_filter

/* File: verif/hbc_mcu_model.sv */
// Purpose: controller stand-in that drives the bridge control and disable pins.
// Assumes: the bench asks for a pin pair through cmd_i; pins move just after a rising edge.
// Notes: lag_i, latched while the pins match cmd_i, holds the old pins that many cycles after the next request, like a slow firmware loop.
`timescale 1ns/1ps
module hbc_mcu_model (
	input  wire logic       mclk_i,
	input  wire logic [1:0] cmd_i,
	input  wire logic       off_i,
	input  wire logic [3:0] lag_i,
	output logic            in1_o,
	output logic            in2_o,
	output logic            disable_o
);
	logic [3:0] wait_ff;

	// pins start quiet with the bridge disabled
	initial begin
		{in1_o, in2_o} = 2'h0;
		disable_o = 1'b1;
		wait_ff = 4'h0;
	end

	// a new pair is held whole until the next request, long past the input filter
	always @(posedge mclk_i) begin
		disable_o <= off_i;
		if ({in1_o, in2_o} == cmd_i) begin
			wait_ff <= lag_i;
		end else if (wait_ff != 4'h0) begin
			wait_ff <= wait_ff - 4'h1;
		end else begin
			{in1_o, in2_o} <= cmd_i;
		end
	end
endmodule : hbc_mcu_model

/* File: verif/test_hbridge_current_chopper_ctrl.sv */
// Purpose: self-checking bench for the chopper controller with a controller model on the pins.
// Assumes: 10 MHz clock, retry count shortened to 50 cycles, PWM mode strap.
// Notes: drivers queue expected values; the monitor judges them at the probe edge.
`timescale 1ns/1ps
module test_hbridge_current_chopper_ctrl;
	import hbc_pkg::*;
	typedef struct packed {logic [2:0] sel; logic [7:0] val;} hbc_note_s;
	logic       mclk_i, reset_i, sleep_n_i, variant_serial_i, regulation_disable_strap_n_i;
	logic       reg_wr_i, reg_rd_i, probe, go_off, in1_i, in2_i, disable_i;
	logic       fault_out_n_o, fault_out_n_oe_o, awake_o, line_n;
	logic [1:0] regulation_trip_i, ocp_i, mode_strap_i, cmd, hs_on_o, ls_on_o, trip_level_select_o;
	logic [2:0] slew_strap_i, slew_select_o;
	logic [3:0] lag;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, obs;
	logic [1:0] mk [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
	logic [1:0] tv [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
	logic       rg [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	hbc_note_s  notes[$];
	hbc_note_s  note;
	int         mismatches, n_tests, cycles, i, p, len, base;

	// open-drain fault wire with its pull-up
	assign line_n = fault_out_n_oe_o ? fault_out_n_o : 1'b1;

	hbc_bridge_ctrl #(.RETRY_CYC(50)) DUT (.mclk_i, .reset_i, .sleep_n_i, .in1_i, .in2_i, .disable_i,
		.regulation_trip_i, .ocp_i, .variant_serial_i, .mode_strap_i, .regulation_disable_strap_n_i,
		.slew_strap_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .hs_on_o, .ls_on_o,
		.trip_level_select_o, .slew_select_o, .fault_out_n_o, .fault_out_n_oe_o, .awake_o);
	hbc_mcu_model mcu (.mclk_i(mclk_i), .cmd_i(cmd), .off_i(go_off), .lag_i(lag), .in1_o(in1_i),
		.in2_o(in2_i), .disable_o(disable_i));

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic stop_test;
		if (mismatches == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : wait_cyc

	// sel 0 read data, 1 gates {hs,ls}, 2 trip code, 3 slew code, 4 fault wire, 5 awake
	task automatic chk(input logic [2:0] sel, input logic [7:0] val);
		notes.push_back({sel, val});
		probe <= 1'b1;
		@(posedge mclk_i);
		probe <= 1'b0;
		@(posedge mclk_i);
	endtask : chk

	// the extra edge keeps two strobes from being assigned in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		chk(3'd0, e);
	endtask : rd

	// the oldest note is judged against what stood just before the probe edge
	always @(posedge mclk_i) begin
		if (probe) begin
			note = notes.pop_front();
			case (note.sel)
				3'd0: obs = reg_rdata_o;
				3'd1: obs = {4'h0, hs_on_o, ls_on_o};
				3'd2: obs = {6'h0, trip_level_select_o};
				3'd3: obs = {5'h0, slew_select_o};
				3'd4: obs = {7'h0, line_n};
				default: obs = {7'h0, awake_o};
			endcase
			n_tests++;
			if (obs !== note.val) begin
				mismatches++;
				$display("[ERR] %0t ns: view %0d got %h expected %h", $time, note.sel, obs, note.val);
			end
		end
	end

	// a hang is cut well past the roughly eight thousand cycles planned
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		{reset_i, sleep_n_i, variant_serial_i, regulation_disable_strap_n_i} = 4'b1110;
		{reg_wr_i, reg_rd_i, probe, go_off} = 4'b0001;
		{regulation_trip_i, ocp_i, cmd} = 6'h0;
		mode_strap_i = MD_PWM;
		slew_strap_i = 3'h0;
		lag = 4'h0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		void'($urandom(55));
		base = $urandom % 8;
		wait_cyc(5);
		reset_i <= 1'b0;
		wait_cyc(2);
		chk(3'd4, 8'h00);
		wait_cyc(120);
		chk(3'd4, 8'h01);
		rd(OFS_CTRL4, 8'h12);
		rd(8'h10, 8'h00);
		// controller sets forward drive; the lag of 7 set alongside is not yet latched, so the pins move at once
		lag <= 4'h7;
		cmd <= 2'b10;
		go_off <= 1'b0;
		wait_cyc(60);
		chk(3'd1, 8'h06);
		lag <= 4'h0;
		for (i = 0; i < 4; i++) begin
			wr(OFS_CTRL4, 8'(i + 16));
			chk(3'd2, 8'(i));
		end
		for (i = 0; i < 8; i++) begin
			wr(OFS_CFG, 8'(32 + (i + base) % 8));
			chk(3'd3, 8'((i + base) % 8));
		end
		wr(OFS_CFG, 8'h20);
		// every off time: hold trip through one period, drop it in the second
		for (i = 0; i < 4; i++) begin
			len = (i + 1) * 200;
			wr(OFS_CTRL4, 8'(i * 16 + 2));
			wait_cyc(30);
			regulation_trip_i <= 2'h1;
			wait_cyc(len - 20);
			chk(3'd1, 8'h0C);
			wait_cyc(60);
			chk(3'd1, 8'h0C);
			regulation_trip_i <= 2'h0;
			wait_cyc(len - 66);
			chk(3'd1, 8'h0C);
			wait_cyc(60);
			chk(3'd1, 8'h06);
		end
		for (i = 0; i < 5; i++) begin
			wr(OFS_CTRL4, {4'h0, mk[i], 2'h2});
			regulation_trip_i <= tv[i];
			wait_cyc(100);
			chk(3'd1, rg[i] ? 8'h0C : 8'h06);
			regulation_trip_i <= 2'h0;
			wait_cyc(260);
		end
		// trip inside the blanking after a direction change, then swap during off
		wr(OFS_CTRL4, 8'h02);
		wait_cyc(30);
		cmd <= 2'b01;
		wait_cyc(10);
		regulation_trip_i <= 2'h1;
		wait_cyc(8);
		chk(3'd1, 8'h09);
		wait_cyc(38);
		chk(3'd1, 8'h0C);
		cmd <= 2'b10;
		wait_cyc(22);
		chk(3'd1, 8'h06);
		regulation_trip_i <= 2'h0;
		wait_cyc(300);
		for (p = 0; p < 4; p++) begin
			wr(OFS_CFG, 8'(32 + p * 8));
			ocp_i <= 2'h1;
			wait_cyc(20);
			chk(3'd1, p < 2 ? 8'h00 : 8'h06);
			chk(3'd4, p < 3 ? 8'h00 : 8'h01);
			ocp_i <= 2'h0;
			wait_cyc(80);
			chk(3'd4, (p == 0 || p == 2) ? 8'h00 : 8'h01);
			wr(OFS_CTRL3, 8'h01);
			wait_cyc(40);
			chk(3'd4, 8'h01);
			chk(3'd1, 8'h06);
		end
		// independent halves with output two parked, then phase/enable reverses the bridge
		wr(OFS_CFG, 8'h40);
		wr(OFS_CTRL3, 8'h04);
		wait_cyc(10);
		chk(3'd1, 8'h04);
		wr(OFS_CTRL3, 8'h00);
		wr(OFS_CFG, 8'h00);
		wait_cyc(10);
		chk(3'd1, 8'h09);
		wr(OFS_CFG, 8'h20);
		// sleep, then wake as the pin-strapped variant
		wr(OFS_CTRL4, 8'h33);
		sleep_n_i <= 1'b0;
		variant_serial_i <= 1'b0;
		slew_strap_i <= 3'h5;
		wait_cyc(10);
		chk(3'd5, 8'h00);
		chk(3'd1, 8'h00);
		rd(OFS_CTRL4, 8'h00);
		sleep_n_i <= 1'b1;
		wait_cyc(5);
		chk(3'd4, 8'h00);
		wait_cyc(120);
		chk(3'd4, 8'h01);
		chk(3'd5, 8'h01);
		rd(OFS_CTRL4, 8'h12);
		chk(3'd2, 8'h02);
		chk(3'd3, 8'h07);
		slew_strap_i <= 3'h3;
		wait_cyc(5);
		chk(3'd3, 8'h03);
		slew_strap_i <= 3'h0;
		wait_cyc(5);
		chk(3'd3, 8'h00);
		// a short decay request must be ignored: off stays at the fixed 400 cycles
		wr(OFS_CTRL4, 8'h02);
		wait_cyc(40);
		regulation_trip_i <= 2'h1;
		wait_cyc(20);
		regulation_trip_i <= 2'h0;
		wait_cyc(270);
		chk(3'd1, 8'h0C);
		wait_cyc(200);
		chk(3'd1, 8'h06);
		regulation_disable_strap_n_i <= 1'b1;
		wait_cyc(5);
		regulation_trip_i <= 2'h1;
		wait_cyc(100);
		chk(3'd1, 8'h06);
		regulation_trip_i <= 2'h0;
		stop_test();
	end
endmodule : test_hbridge_current_chopper_ctrl
